// ==== rtl/pcp_pkg.sv ====
package pcp_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TBASE_W = 20;
	localparam logic [19:0] TBASE_MAX = 20'hFFFFF;
	localparam logic [19:0] TBASE_RST = 20'h00000;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	// Receive gain: index k is GAIN_MIN_DB plus k steps of GAIN_STEP_DB
	localparam int GAIN_N = 8;
	localparam int GAIN_W = 3;
	localparam int GAIN_MIN_DB = 0;
	localparam int GAIN_STEP_DB = 3;
	localparam int GAIN_TOP_DB = GAIN_MIN_DB + (GAIN_N - 1) * GAIN_STEP_DB;
	localparam logic [2:0] GAIN_RST = 3'h0;
	localparam logic GAIN_MODE_AUTO = 1'b0;
	localparam logic GAIN_MODE_MANUAL = 1'b1;

	// Level widths
	localparam int RSSI_W = 4;
	localparam int NOISE_W = 4;
	localparam int SNR_W = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_REQ = 8'h00;
	localparam logic [7:0] OFS_CNF = 8'h04;
	localparam logic [7:0] OFS_DATA0 = 8'h08;
	localparam logic [7:0] OFS_DATA1 = 8'h0C;
	localparam logic [7:0] OFS_TIME = 8'h10;

	// Request word fields
	localparam int REQ_SVC_LSB = 0;
	localparam int REQ_SET_BIT = 3;
	localparam int REQ_MODE_BIT = 8;
	localparam int REQ_GAIN_LSB = 12;

	// Confirm word fields
	localparam int CNF_VALID_BIT = 0;
	localparam int CNF_SVC_LSB = 1;
	localparam int CNF_REFUSED_BIT = 4;

	// Carrier confirm fields in DATA1
	localparam int CS_FLAG_BIT = 0;
	localparam int CS_HDR_BIT = 1;
	localparam int CS_RSSI_LSB = 4;

	// Gain confirm fields in DATA0
	localparam int GC_GAIN_LSB = 0;
	localparam int GC_MODE_BIT = 8;

	typedef enum logic [2:0] {
		SVC_GAIN = 3'h0,
		SVC_TIME = 3'h1,
		SVC_CARRIER = 3'h2,
		SVC_NOISE = 3'h3,
		SVC_SNR = 3'h4,
		SVC_ZC = 3'h5
	} pcp_svc_t;

	typedef enum {
		CS_IDLE,
		CS_HDR,
		CS_BODY
	} pcp_cs_t;
endpackage : pcp_pkg

// ==== rtl/pcp_tbase.sv ====
`timescale 1ns/10ps
module pcp_tbase (
	input wire logic core_clk,
	input wire logic rstn,
	output logic [pcp_pkg::TBASE_W-1:0] tbase
);
	import pcp_pkg::*;

	logic [7:0] pre_q;
	logic [7:0] pre_d;
	logic [TBASE_W-1:0] cnt_q;
	logic [TBASE_W-1:0] cnt_d;

	// Free running, never held: wraps to zero after TBASE_MAX, and reset returns it to zero
	always_comb begin
		pre_d = pre_q + 8'h01;
		cnt_d = cnt_q;
		if (pre_q == TICK_LAST) begin
			pre_d = 8'h00;
			cnt_d = (cnt_q == TBASE_MAX) ? TBASE_RST : cnt_q + 20'h00001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pre_q <= 8'h00;
			cnt_q <= TBASE_RST;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end

	assign tbase = cnt_q;
endmodule : pcp_tbase

// ==== rtl/pcp_ctrl.sv ====
`timescale 1ns/10ps
module pcp_ctrl (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic preamble_det,
	input wire logic header_ok,
	input wire logic header_fail,
	input wire logic [pcp_pkg::TBASE_W-1:0] header_end_time,
	input wire logic [pcp_pkg::TBASE_W-1:0] ppdu_end_time,
	input wire logic [pcp_pkg::RSSI_W-1:0] rssi_level,
	input wire logic [pcp_pkg::NOISE_W-1:0] noise_level,
	input wire logic [pcp_pkg::SNR_W-1:0] snr_level,
	input wire logic frame_done,
	input wire logic link_event,
	input wire logic zero_cross_pin,
	input wire logic [pcp_pkg::GAIN_W-1:0] agc_gain_now,
	output logic rx_gain_mode,
	output logic [pcp_pkg::GAIN_W-1:0] rx_gain_idx,
	output logic agc_start_load,
	output logic [pcp_pkg::GAIN_W-1:0] agc_start_gain
);
	import pcp_pkg::*;

	// Gain range must meet the 21 dB top and 6 dB step limits
	localparam logic GAIN_RANGE_OK = (GAIN_TOP_DB >= 21) && (GAIN_STEP_DB <= 6);

	function automatic logic [7:0] reg_ofs(input logic [31:0] a);
		reg_ofs = {a[7:2], 2'b00};
	endfunction : reg_ofs

	logic [TBASE_W-1:0] tbase;

	pcp_tbase u_tbase (
		.core_clk(core_clk),
		.rstn(rstn),
		.tbase(tbase)
	);

	// Bus state
	logic wr_pend_q, wr_pend_d;
	logic rd_pend_q, rd_pend_d;
	logic [7:0] addr_q, addr_d;
	logic hreadyout_q, hreadyout_d;
	logic [31:0] hrdata_q, hrdata_d;

	// Confirm state
	logic cnf_valid_q, cnf_valid_d;
	logic cnf_refused_q, cnf_refused_d;
	logic [2:0] cnf_svc_q, cnf_svc_d;
	logic [31:0] data0_q, data0_d;
	logic [31:0] data1_q, data1_d;

	// Gain state
	logic mode_q, mode_d;
	logic [GAIN_W-1:0] gain_cfg_q, gain_cfg_d;
	logic [GAIN_W-1:0] gain_app_q, gain_app_d;
	logic load_q, load_d;

	// Carrier state
	pcp_cs_t cs_q, cs_d;
	logic [TBASE_W-1:0] cs_time_q, cs_time_d;
	logic [RSSI_W-1:0] rssi_q, rssi_d;
	logic [SNR_W-1:0] snr_q, snr_d;

	// Mains crossing state
	logic zc_s1_q, zc_s2_q, zc_s3_q;
	logic zc_stable_q, zc_stable_d;
	logic [TBASE_W-1:0] zc_time_q, zc_time_d;
	logic [TBASE_W-1:0] evt_time_q, evt_time_d;

	logic acc;
	logic [2:0] req_svc;
	logic req_set;
	logic req_hit;
	logic rd_cnf;
	logic new_cnf;
	logic new_ref;
	logic [GAIN_W-1:0] gain_next;

	always_comb begin
		wr_pend_d = 1'b0;
		rd_pend_d = 1'b0;
		addr_d = addr_q;
		hreadyout_d = 1'b1;
		hrdata_d = hrdata_q;
		cnf_valid_d = cnf_valid_q;
		cnf_refused_d = cnf_refused_q;
		cnf_svc_d = cnf_svc_q;
		data0_d = data0_q;
		data1_d = data1_q;
		mode_d = mode_q;
		gain_cfg_d = gain_cfg_q;
		load_d = 1'b0;
		new_cnf = 1'b0;
		new_ref = 1'b0;
		rd_cnf = 1'b0;
		gain_next = gain_app_q;
		req_svc = hwdata[REQ_SVC_LSB +: 3];
		req_set = hwdata[REQ_SET_BIT];
		req_hit = wr_pend_q && (addr_q == OFS_REQ);

		// Address phase; reads take one wait state so a write just before is seen
		acc = hsel && htrans[1] && hready;
		if (acc) begin
			wr_pend_d = hwrite;
			rd_pend_d = !hwrite;
			addr_d = reg_ofs(haddr);
			hreadyout_d = hwrite;
		end

		// Request handling in the write data phase
		if (req_hit) begin
			if (req_set && (req_svc != SVC_GAIN)) begin
				new_ref = 1'b1;
			end else begin
				new_cnf = 1'b1;
				cnf_svc_d = req_svc;
				data0_d = 32'h00000000;
				data1_d = 32'h00000000;
				case (req_svc)
					SVC_GAIN: begin
						if (req_set) begin
							mode_d = hwdata[REQ_MODE_BIT];
							gain_cfg_d = hwdata[REQ_GAIN_LSB +: GAIN_W];
							load_d = (hwdata[REQ_MODE_BIT] == GAIN_MODE_AUTO);
							gain_next = hwdata[REQ_GAIN_LSB +: GAIN_W];
						end
						data0_d[GC_MODE_BIT] = mode_d;
						data0_d[GC_GAIN_LSB +: GAIN_W] = gain_next;
					end
					SVC_TIME: data0_d[TBASE_W-1:0] = tbase;
					SVC_CARRIER: begin
						if (cs_q != CS_IDLE) begin
							data0_d[TBASE_W-1:0] = cs_time_q;
							data1_d[CS_FLAG_BIT] = 1'b1;
							data1_d[CS_RSSI_LSB +: RSSI_W] = rssi_q;
						end
						data1_d[CS_HDR_BIT] = (cs_q == CS_HDR);
					end
					SVC_NOISE: data0_d[NOISE_W-1:0] = noise_level;
					SVC_SNR: data0_d[SNR_W-1:0] = snr_q;
					SVC_ZC: begin
						data0_d[TBASE_W-1:0] = zc_time_q;
						data1_d[TBASE_W-1:0] = zc_time_q - evt_time_q;
					end
					default: begin
						// Unknown services are refused and leave the last confirm intact
						new_cnf = 1'b0;
						new_ref = 1'b1;
						cnf_svc_d = cnf_svc_q;
						data0_d = data0_q;
						data1_d = data1_q;
					end
				endcase
			end
		end

		// Read data phase; reading the confirm word clears its flags
		if (rd_pend_q) begin
			case (addr_q)
				OFS_CNF: begin
					hrdata_d = 32'h00000000;
					hrdata_d[CNF_VALID_BIT] = cnf_valid_q;
					hrdata_d[CNF_SVC_LSB +: 3] = cnf_svc_q;
					hrdata_d[CNF_REFUSED_BIT] = cnf_refused_q;
					rd_cnf = 1'b1;
				end
				OFS_DATA0: hrdata_d = data0_q;
				OFS_DATA1: hrdata_d = data1_q;
				OFS_TIME: hrdata_d = {12'h000, tbase};
				default: hrdata_d = 32'h00000000;
			endcase
		end

		// A new confirm in the clearing cycle survives
		if (rd_cnf) begin
			cnf_valid_d = 1'b0;
			cnf_refused_d = 1'b0;
		end
		if (new_cnf) begin
			cnf_valid_d = 1'b1;
		end
		if (new_ref) begin
			cnf_refused_d = 1'b1;
		end
	end

	// Applied gain follows the loop in auto mode, except on the start load
	always_comb begin
		if (mode_d == GAIN_MODE_MANUAL) begin
			gain_app_d = gain_cfg_d;
		end else if (load_d) begin
			gain_app_d = gain_cfg_d;
		end else begin
			gain_app_d = agc_gain_now;
		end
	end

	// Carrier tracking: a preamble alone gives a pending header, header
	// recognition gives the frame end; a failed header drops the carrier
	always_comb begin
		cs_d = cs_q;
		cs_time_d = cs_time_q;
		rssi_d = rssi_q;
		snr_d = snr_q;
		case (cs_q)
			CS_IDLE: begin
				cs_time_d = TBASE_RST;
				if (preamble_det) begin
					cs_d = CS_HDR;
					cs_time_d = header_end_time;
					rssi_d = rssi_level;
				end
			end
			CS_HDR: begin
				if (header_fail) begin
					cs_d = CS_IDLE;
					cs_time_d = TBASE_RST;
				end else if (header_ok) begin
					cs_d = CS_BODY;
					cs_time_d = ppdu_end_time;
				end
			end
			CS_BODY: begin
				if (frame_done || (tbase == cs_time_q)) begin
					cs_d = CS_IDLE;
					cs_time_d = TBASE_RST;
				end
			end
			default: begin
				cs_d = CS_IDLE;
				cs_time_d = TBASE_RST;
			end
		endcase
		if (frame_done) begin
			snr_d = snr_level;
		end
	end

	// Crossing edge counts once the second and third stages agree
	always_comb begin
		zc_stable_d = zc_stable_q;
		zc_time_d = zc_time_q;
		evt_time_d = evt_time_q;
		if ((zc_s2_q == zc_s3_q) && (zc_s3_q != zc_stable_q)) begin
			zc_stable_d = zc_s3_q;
			if (zc_s3_q) begin
				zc_time_d = tbase;
			end
		end
		if (link_event) begin
			evt_time_d = tbase;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
			cnf_valid_q <= 1'b0;
			cnf_refused_q <= 1'b0;
			cnf_svc_q <= 3'h0;
			data0_q <= 32'h00000000;
			data1_q <= 32'h00000000;
			mode_q <= GAIN_MODE_AUTO;
			gain_cfg_q <= GAIN_RST;
			gain_app_q <= GAIN_RST;
			load_q <= 1'b0;
			cs_q <= CS_IDLE;
			cs_time_q <= TBASE_RST;
			rssi_q <= 4'h0;
			snr_q <= 3'h0;
			zc_s1_q <= 1'b0;
			zc_s2_q <= 1'b0;
			zc_s3_q <= 1'b0;
			zc_stable_q <= 1'b0;
			zc_time_q <= TBASE_RST;
			evt_time_q <= TBASE_RST;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q <= addr_d;
			hreadyout_q <= hreadyout_d;
			hrdata_q <= hrdata_d;
			cnf_valid_q <= cnf_valid_d;
			cnf_refused_q <= cnf_refused_d;
			cnf_svc_q <= cnf_svc_d;
			data0_q <= data0_d;
			data1_q <= data1_d;
			mode_q <= mode_d;
			gain_cfg_q <= gain_cfg_d;
			gain_app_q <= gain_app_d;
			load_q <= load_d && GAIN_RANGE_OK;
			cs_q <= cs_d;
			cs_time_q <= cs_time_d;
			rssi_q <= rssi_d;
			snr_q <= snr_d;
			zc_s1_q <= zero_cross_pin;
			zc_s2_q <= zc_s1_q;
			zc_s3_q <= zc_s2_q;
			zc_stable_q <= zc_stable_d;
			zc_time_q <= zc_time_d;
			evt_time_q <= evt_time_d;
		end
	end

	// Response is always OKAY
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign rx_gain_mode = mode_q;
	assign rx_gain_idx = gain_app_q;
	assign agc_start_load = load_q;
	assign agc_start_gain = gain_cfg_q;
endmodule : pcp_ctrl

// ==== bench/pcp_ctrl_assertions.sv ====
`timescale 1ns/10ps
module pcp_ctrl_chk (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [pcp_pkg::GAIN_W-1:0] agc_gain_now,
	input wire logic rx_gain_mode,
	input wire logic [pcp_pkg::GAIN_W-1:0] rx_gain_idx,
	input wire logic agc_start_load,
	input wire logic [pcp_pkg::GAIN_W-1:0] agc_start_gain
);
	import pcp_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence addr_s(logic w, logic [7:0] a);
		hsel && htrans[1] && hready && hwrite == w && haddr[7:0] == a;
	endsequence
	sequence gset_s(logic m);
		addr_s(1'b1, OFS_REQ) ##1 hwdata[3:0] == 4'h8 && hwdata[8] == m;
	endsequence
	bus_okay_a:
		assert property (!hresp) else $error("bus response not OKAY");
	read_wait_a:
		assert property (addr_s(1'b0, OFS_CNF) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	mode_adopt_a:
		assert property (addr_s(1'b1, OFS_REQ) ##1 hwdata[3:0] == 4'h8
			|=> rx_gain_mode == $past(hwdata[8])) else $error("gain mode not adopted");
	auto_load_a:
		assert property (gset_s(GAIN_MODE_AUTO) |-> ##[1:2] agc_start_load)
		else $error("start gain not loaded");
	start_gain_a:
		assert property (gset_s(GAIN_MODE_AUTO) |=> agc_start_gain == $past(hwdata[14:12]))
		else $error("start gain wrong");
	manual_gain_a:
		assert property (rx_gain_mode == GAIN_MODE_MANUAL |-> rx_gain_idx == agc_start_gain)
		else $error("manual gain not applied");
	set_refused_a:
		assert property (addr_s(1'b1, OFS_REQ) ##1 hwdata[3] && hwdata[2:0] != 3'h0
			|=> $stable(rx_gain_mode) && $stable(agc_start_gain)) else $error("set not refused");
	time_width_a:
		assert property (addr_s(1'b0, OFS_TIME) ##2 hreadyout |-> hrdata[31:20] == 12'h000)
		else $error("time above 20 bits");
	auto_follow_a:
		assert property (rx_gain_mode == GAIN_MODE_AUTO && !agc_start_load
			|-> rx_gain_idx == $past(agc_gain_now)) else $error("auto gain not followed");
	start_apply_a:
		assert property (agc_start_load |-> rx_gain_idx == agc_start_gain)
		else $error("start gain not applied");
endmodule : pcp_ctrl_chk
bind pcp_ctrl pcp_ctrl_chk u_pcp_ctrl_chk (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .hrdata, .agc_gain_now, .rx_gain_mode, .rx_gain_idx,
	.agc_start_load, .agc_start_gain);

// ==== bench/pcp_mac_model.sv ====
`timescale 1ns/10ps
module pcp_mac_model (
	input wire logic core_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'b1,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'h2,
	output logic [31:0] hwdata = 32'h0
);
	// Single words, one at a time; data inverts when not valid so stale values never match
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge core_clk); while (!hready);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge core_clk); while (!hready);
		r = hrdata;
	endtask : xfer
endmodule : pcp_mac_model

// ==== bench/plc_phy_control_plane_tb_top.sv ====
`timescale 1ns/10ps
module plc_phy_control_plane_tb_top;
	import pcp_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, zero_cross_pin = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, rx_gain_mode, agc_start_load;
	wire preamble_det, header_ok, header_fail, frame_done, link_event;
	logic [4:0] ev = 5'h0;
	logic [1:0] htrans;
	logic [2:0] hsize, rx_gain_idx, agc_start_gain, g, sn, snr_level = 3'h0, agc_gain_now = 3'h0;
	logic [3:0] rssi_level = 4'h0, noise_level = 4'h0, rs, nz;
	logic [19:0] header_end_time = 20'h0, ppdu_end_time = 20'h0, he, pe;
	logic [31:0] haddr, hwdata, hrdata, rd, d0, d1, t0, ce, seed = 32'h8B84A488;
	logic [2:0] lsv = 3'h0;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	assign {link_event, frame_done, header_fail, header_ok, preamble_det} = ev;
	always #25 core_clk = ~core_clk;
	pcp_mac_model u_pcp_mac_model (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	pcp_ctrl u_pcp_ctrl (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .preamble_det, .header_ok, .header_fail,
		.header_end_time, .ppdu_end_time, .rssi_level, .noise_level, .snr_level, .frame_done,
		.link_event, .zero_cross_pin, .agc_gain_now, .rx_gain_mode, .rx_gain_idx,
		.agc_start_load, .agc_start_gain);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] cnf_word(input logic v, input logic [2:0] s, input logic r);
		return {27'h0, r, s, v};
	endfunction : cnf_word
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
		u_pcp_mac_model.xfer(w, a, d, rd);
	endtask : bus
	task automatic pulse(input int i);
		@(posedge core_clk);
		ev[i] <= 1'b1;
		@(posedge core_clk);
		ev[i] <= 1'b0;
	endtask : pulse
	task automatic req(input logic [31:0] w, input logic refused);
		bus(1'b1, OFS_REQ, w);
		bus(1'b0, OFS_CNF);
		// A refusal leaves the tag of the last accepted service in place
		ce = refused ? cnf_word(1'b0, lsv, 1'b1) : cnf_word(1'b1, w[2:0], 1'b0);
		chk("confirm", ce, rd);
		if (!refused)
			lsv = w[2:0];
		bus(1'b0, OFS_DATA0);
		d0 = rd;
		bus(1'b0, OFS_DATA1);
		d1 = rd;
	endtask : req
	task automatic q(input logic [2:0] s, input logic [31:0] e0, input logic [31:0] e1);
		req({29'h0, s}, 1'b0);
		chk("data0", e0, d0);
		chk("data1", e1, d1);
	endtask : q
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		// Auto sets use the loop's own gain so both readings of the confirm agree
		for (int i = 0; i < 6; i++) begin
			g = (i == 5) ? 3'h7 : 3'(rnd());
			agc_gain_now <= g;
			req({17'h0, g, 3'h0, i[0], 8'h08}, 1'b0);
			chk("gain_set", {23'h0, i[0], 5'h0, g}, d0);
			agc_gain_now <= 3'(g + 3'h1);
			q(3'h0, {23'h0, i[0], 5'h0, i[0] ? g : 3'(g + 3'h1)}, 32'h0);
		end
		bus(1'b0, OFS_TIME);
		t0 = rd;
		repeat (396) @(posedge core_clk);
		bus(1'b0, OFS_TIME);
		chk("time_step", t0 + 32'h2, rd);
		// Start just after a tick so both stamps land in known ticks
		t0 = rd;
		do bus(1'b0, OFS_TIME); while (rd === t0);
		pulse(4);
		repeat (200) @(posedge core_clk);
		zero_cross_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		bus(1'b0, OFS_TIME);
		q(3'h5, rd, 32'h1);
		he = 20'h80000 | 20'(rnd());
		pe = 20'hC0000 | 20'(rnd());
		rs = 4'(rnd());
		header_end_time <= he;
		ppdu_end_time <= pe;
		rssi_level <= rs;
		q(3'h2, 32'h0, 32'h0);
		pulse(0);
		q(3'h2, {12'h0, he}, {24'h0, rs, 4'h3});
		pulse(1);
		q(3'h2, {12'h0, pe}, {24'h0, rs, 4'h1});
		// A finished frame ends the carrier and fixes its quality index
		sn = 3'(rnd());
		snr_level <= sn;
		pulse(3);
		snr_level <= ~sn;
		q(3'h2, 32'h0, 32'h0);
		// A failed header drops a pending carrier
		pulse(0);
		pulse(2);
		q(3'h2, 32'h0, 32'h0);
		// The carrier also ends once the time base reaches the frame end
		bus(1'b0, OFS_TIME);
		pe = 20'(rd + 32'h2);
		ppdu_end_time <= pe;
		pulse(0);
		pulse(1);
		q(3'h2, {12'h0, pe}, {24'h0, rs, 4'h1});
		repeat (600) @(posedge core_clk);
		q(3'h2, 32'h0, 32'h0);
		nz = 4'(rnd());
		noise_level <= nz;
		q(3'h3, {28'h0, nz}, 32'h0);
		q(3'h4, {29'h0, sn}, 32'h0);
		for (int s = 1; s < 8; s++) begin
			req({28'h0, 1'b1, 3'(s)}, 1'b1);
			chk("kept", {29'h0, sn}, d0);
		end
		req({29'h0, 3'h6}, 1'b1);
		chk("kept", {29'h0, sn}, d0);
		bus(1'b0, OFS_CNF);
		chk("cnf_clear", cnf_word(1'b0, lsv, 1'b0), rd);
		bus(1'b0, 8'h20);
		chk("unmapped", 32'h0, rd);
		report_and_stop();
	end
endmodule : plc_phy_control_plane_tb_top
